/* File: psw_defs.svh */
// offsets, field positions, reset values and sizes for the status word block
`ifndef PSW_DEFS_SVH
`define PSW_DEFS_SVH
`define PSW_STATUS_ADDR     8'hD0
`define PSW_RESET_VAL       8'h00
`define PSW_BIT_CARRY       7
`define PSW_BIT_HALF        6
`define PSW_BIT_USER_A      5
`define PSW_BIT_BANK_HI     4
`define PSW_BIT_BANK_LO     3
`define PSW_BIT_RANGE       2
`define PSW_BIT_USER_B      1
`define PSW_BIT_PARITY      0
`define PSW_BITAREA_BASE    8'h20
`define PSW_LOWER_TOP       8'h7F
`define PSW_PROG_LIMIT_BIG  16'h3E00
`define PSW_PROG_LIMIT_SMALL 16'h2000
`define PSW_XRAM_ADDR_W     10
`endif

/* File: psw_pkg.sv */
// types shared by the status word block
package psw_pkg;
    // arithmetic operation reported by the execution unit
    typedef enum logic [2:0] {
        PSW_OP_NONE = 3'b000,
        PSW_OP_ADD  = 3'b001,
        PSW_OP_ADDC = 3'b010,
        PSW_OP_SUBB = 3'b011,
        PSW_OP_MUL  = 3'b100,
        PSW_OP_DIV  = 3'b101,
        PSW_OP_OTH  = 3'b110
    } psw_op_t;
    // which data space a decoded access lands in
    typedef enum logic [1:0] {
        PSW_SP_LOWER = 2'b00,
        PSW_SP_UPPER = 2'b01,
        PSW_SP_SPEC  = 2'b10,
        PSW_SP_XRAM  = 2'b11
    } psw_space_t;
endpackage

/* File: psw_flag_calc.sv */
// combinational flag results for arithmetic operations
`timescale 1ns/1ns
module psw_flag_calc (
    // operands
    input  wire logic [7:0]     op_a,
    input  wire logic [7:0]     op_b,
    input  wire logic           carry_in,
    input  wire psw_pkg::psw_op_t op_kind,
    // flag results
    output logic                arith_op,
    output logic                cy_out,
    output logic                ac_out,
    output logic                range_upd,
    output logic                range_out
);
    logic [8:0]  sum9;
    logic [4:0]  nib5;
    logic [15:0] prod;
    logic        cin;

    // results of one operation; carry only feeds in for addc/subb
    always_comb begin
        cin       = (op_kind == psw_pkg::PSW_OP_ADDC ||
                     op_kind == psw_pkg::PSW_OP_SUBB) ? carry_in : 1'b0;
        sum9      = 9'h000;
        nib5      = 5'h00;
        prod      = op_a * op_b;
        arith_op  = 1'b0;
        cy_out    = 1'b0;
        ac_out    = 1'b0;
        range_upd = 1'b0;
        range_out = 1'b0;
        unique case (op_kind)
            psw_pkg::PSW_OP_ADD, psw_pkg::PSW_OP_ADDC: begin
                sum9      = {1'b0, op_a} + {1'b0, op_b} + {8'h00, cin};
                nib5      = {1'b0, op_a[3:0]} + {1'b0, op_b[3:0]}
                            + {4'h0, cin};
                arith_op  = 1'b1;
                cy_out    = sum9[8];
                ac_out    = nib5[4];
                range_upd = 1'b1;
                range_out = (op_a[7] == op_b[7]) &&
                            (sum9[7] != op_a[7]);
            end
            psw_pkg::PSW_OP_SUBB: begin
                sum9      = {1'b0, op_a} - {1'b0, op_b} - {8'h00, cin};
                nib5      = {1'b0, op_a[3:0]} - {1'b0, op_b[3:0]}
                            - {4'h0, cin};
                arith_op  = 1'b1;
                cy_out    = sum9[8];
                ac_out    = nib5[4];
                range_upd = 1'b1;
                range_out = (op_a[7] != op_b[7]) &&
                            (sum9[7] != op_a[7]);
            end
            psw_pkg::PSW_OP_MUL: begin
                arith_op  = 1'b1;
                range_upd = 1'b1;
                range_out = (prod[15:8] != 8'h00);
            end
            psw_pkg::PSW_OP_DIV: begin
                arith_op  = 1'b1;
                range_upd = 1'b1;
                range_out = (op_b == 8'h00);
            end
            psw_pkg::PSW_OP_OTH: begin
                arith_op  = 1'b1;                   // clears carries only
            end
            default: begin
            end
        endcase
    end
endmodule // psw_flag_calc

/* File: psw_xram.sv */
// on-chip data memory with registered read data
`timescale 1ns/1ns
module psw_xram #(
    parameter int AW = 10
) (
    // clock
    input  wire logic          core_clk,
    // port
    input  wire logic [AW-1:0] addr,
    input  wire logic          wr_en,
    input  wire logic [7:0]    wr_data,
    output logic [7:0]         rd_data
);
    logic [7:0] mem [0:(1<<AW)-1];

    // read before write, read registered
    always_ff @(posedge core_clk) begin
        if (wr_en) begin
            mem[addr] <= wr_data;
        end
        rd_data <= mem[addr];
    end
endmodule // psw_xram

/* File: psw_status_map.sv */
// status word register and memory space decode for the core
// Overview of operation
// - carry set on carry or borrow, else cleared
// - half carry set on nibble carry or borrow
// - two user flags, software only
// - bank field picks register bank of eight
// - signed overflow on add/addc/subb sets range flag
// - multiply product above 255 sets range flag
// - divide by zero sets range flag
// - range flag cleared when no overflow
// - parity bit read-only, odd ones reads 1
// - status at 0xD0, bit/byte access, resets zero
// - program space 64k, two size variants
// - big variant top 512 bytes reserved
// - program memory read only, code reads allowed
// - instruction type selects program or data space
// - 256 byte internal ram, lower half both modes
// - bytes 0x00-0x1F are four register banks
// - bytes 0x20-0x2F byte or bit addressable
// - above 0x7F direct=special, indirect=upper ram
// - 1024 byte ram in external data space
// - bit address n below 0x80 maps byte 0x20+n/8 bit n%8
`timescale 1ns/1ns
`include "psw_defs.svh"
module psw_status_map #(
    parameter bit BIG_VARIANT = 1'b1
) (
    // clock and reset
    input  wire logic           core_clk,
    input  wire logic           sys_rst,
    // arithmetic result from execution unit
    input  wire psw_pkg::psw_op_t op_kind,
    input  wire logic [7:0]     op_a,
    input  wire logic [7:0]     op_b,
    input  wire logic [7:0]     acc_value,
    // special register access
    input  wire logic [7:0]     sfr_addr,
    input  wire logic           sfr_wr,
    input  wire logic [7:0]     sfr_wdata,
    input  wire logic           bit_wr,
    input  wire logic [2:0]     bit_sel,
    input  wire logic           bit_val,
    // data access decode request
    input  wire logic           reg_access,
    input  wire logic [2:0]     reg_num,
    input  wire logic [7:0]     data_addr,
    input  wire logic           data_indirect,
    input  wire logic           data_bit,
    input  wire logic           ext_access,
    input  wire logic [15:0]    ext_addr,
    input  wire logic           ext_wr,
    input  wire logic [7:0]     ext_wdata,
    // program access
    input  wire logic           code_access,
    input  wire logic [15:0]    code_addr,
    // outputs
    output logic [7:0]          status_word,
    output logic [7:0]          mapped_addr_r,
    output logic [2:0]          mapped_bit_r,
    output psw_pkg::psw_space_t mapped_space_r,
    output logic                code_valid_r,
    output logic                code_addr_ok_r,
    output logic [7:0]          ext_rdata
);
    logic [7:0]          psw_r, psw_nxt;
    logic [7:0]          addr_nxt;
    logic [2:0]          bit_nxt;
    psw_pkg::psw_space_t space_nxt;
    logic                cvalid_nxt, cok_nxt;
    logic                arith_op, cy_o, ac_o, rng_upd, rng_o;
    logic                parity_r, parity_nxt;

    // --------------------------------------------------------------
    // flag arithmetic
    // --------------------------------------------------------------
    psw_flag_calc u_calc (
        .op_a      (op_a),
        .op_b      (op_b),
        .carry_in  (psw_r[`PSW_BIT_CARRY]),
        .op_kind   (op_kind),
        .arith_op  (arith_op),
        .cy_out    (cy_o),
        .ac_out    (ac_o),
        .range_upd (rng_upd),
        .range_out (rng_o)
    );

    // --------------------------------------------------------------
    // status word
    // --------------------------------------------------------------
    // software write first, hardware flag update wins on a collision
    always_comb begin
        psw_nxt = psw_r;
        if (sfr_wr && sfr_addr == `PSW_STATUS_ADDR) begin
            psw_nxt = sfr_wdata;
        end
        if (bit_wr && sfr_addr == `PSW_STATUS_ADDR) begin
            psw_nxt[bit_sel] = bit_val;
        end
        if (arith_op) begin
            psw_nxt[`PSW_BIT_CARRY] = cy_o;
            psw_nxt[`PSW_BIT_HALF]  = ac_o;
        end
        if (rng_upd) begin
            psw_nxt[`PSW_BIT_RANGE] = rng_o;
        end
        // user flags only move by the software paths above
        psw_nxt[`PSW_BIT_PARITY] = 1'b0;
        parity_nxt = ^acc_value;
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            psw_r    <= `PSW_RESET_VAL;
            parity_r <= 1'b0;
        end else begin
            psw_r    <= psw_nxt;
            parity_r <= parity_nxt;
        end
    end

    // parity tracks the accumulator one cycle late, never writable
    always_comb begin
        status_word = {psw_r[7:1], parity_r};
    end

    // --------------------------------------------------------------
    // data and program decode
    // --------------------------------------------------------------
    // bank comes from the stored field, so a write lands on the next
    // register access and never on one in the same cycle
    always_comb begin
        addr_nxt   = data_addr;
        bit_nxt    = 3'h0;
        space_nxt  = psw_pkg::PSW_SP_LOWER;
        cvalid_nxt = 1'b0;
        cok_nxt    = 1'b0;
        if (reg_access) begin
            addr_nxt = {3'h0, psw_r[`PSW_BIT_BANK_HI:`PSW_BIT_BANK_LO],
                        reg_num};
        end else if (data_bit) begin
            if (data_addr[7]) begin
                addr_nxt  = {data_addr[7:3], 3'h0};
                space_nxt = psw_pkg::PSW_SP_SPEC;
            end else begin
                addr_nxt = `PSW_BITAREA_BASE
                           + {4'h0, data_addr[6:3]};
            end
            bit_nxt = data_addr[2:0];
        end else if (data_addr > `PSW_LOWER_TOP) begin
            space_nxt = data_indirect ? psw_pkg::PSW_SP_UPPER
                                      : psw_pkg::PSW_SP_SPEC;
        end
        if (ext_access) begin
            addr_nxt  = ext_addr[7:0];
            space_nxt = psw_pkg::PSW_SP_XRAM;
        end
        // code reads come from a separate space; no write exists
        if (code_access) begin
            cvalid_nxt = 1'b1;
            cok_nxt    = BIG_VARIANT ?
                         (code_addr < `PSW_PROG_LIMIT_BIG) :
                         (code_addr < `PSW_PROG_LIMIT_SMALL);
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            mapped_addr_r  <= 8'h00;
            mapped_bit_r   <= 3'h0;
            mapped_space_r <= psw_pkg::PSW_SP_LOWER;
            code_valid_r   <= 1'b0;
            code_addr_ok_r <= 1'b0;
        end else begin
            mapped_addr_r  <= addr_nxt;
            mapped_bit_r   <= bit_nxt;
            mapped_space_r <= space_nxt;
            code_valid_r   <= cvalid_nxt;
            code_addr_ok_r <= cok_nxt;
        end
    end

    // --------------------------------------------------------------
    // external data memory, wrapped modulo its size
    // --------------------------------------------------------------
    psw_xram #(.AW(`PSW_XRAM_ADDR_W)) u_xram (
        .core_clk (core_clk),
        .addr     (ext_addr[`PSW_XRAM_ADDR_W-1:0]),
        .wr_en    (ext_access && ext_wr),
        .wr_data  (ext_wdata),
        .rd_data  (ext_rdata)
    );
endmodule // psw_status_map

/* File: psw_exec_model.sv */
// execution unit model feeding operations to the status block
`timescale 1ns/1ns
module psw_exec_model (
    // clock
    input  wire logic             core_clk,
    // operation asked for by the bench
    input  wire psw_pkg::psw_op_t req_kind,
    input  wire logic [7:0]       req_a,
    input  wire logic [7:0]       req_b,
    // operation as the block sees it
    output psw_pkg::psw_op_t      op_kind = psw_pkg::PSW_OP_NONE,
    output logic [7:0]            op_a = 8'h00,
    output logic [7:0]            op_b = 8'h00,
    output logic [7:0]            acc_value = 8'h00
);
    // one operation per edge; accumulator holds operand a
    always @(posedge core_clk) begin
        op_kind <= req_kind;
        op_a <= req_a;
        op_b <= req_b;
        acc_value <= req_a;
    end
endmodule // psw_exec_model

/* File: psw_status_map_chk.sv */
// bound checker for the status word block
`timescale 1ns/1ns
module psw_status_map_chk (
    // clock and reset
    input wire logic             core_clk,
    input wire logic             sys_rst,
    // operation and requests
    input wire psw_pkg::psw_op_t op_kind,
    input wire logic [7:0]       op_a,
    input wire logic [7:0]       op_b,
    input wire logic [7:0]       acc_value,
    input wire logic             sfr_wr,
    input wire logic             bit_wr,
    input wire logic             reg_access,
    input wire logic [2:0]       reg_num,
    input wire logic             ext_access,
    // results
    input wire logic [7:0]       status_word,
    input wire logic [7:0]       mapped_addr_r
);
    // expected flags worked out from the operands
    wire [8:0]  sum9 = {1'b0, op_a} + {1'b0, op_b};
    wire [4:0]  sum5 = {1'b0, op_a[3:0]} + {1'b0, op_b[3:0]};
    wire        ovf = (op_a[7] == op_b[7]) && (sum9[7] != op_a[7]);
    wire [15:0] prod = op_a * op_b;

    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    AST_ADD_CY: assert property (
        op_kind == psw_pkg::PSW_OP_ADD |=> status_word[7] == $past(sum9[8]))
        else $error("carry wrong after add");
    AST_ADD_HALF: assert property (
        op_kind == psw_pkg::PSW_OP_ADD |=> status_word[6] == $past(sum5[4]))
        else $error("half carry wrong after add");
    AST_ADD_RANGE: assert property (
        op_kind == psw_pkg::PSW_OP_ADD |=> status_word[2] == $past(ovf))
        else $error("range flag wrong after add");
    AST_MUL_RANGE: assert property (
        op_kind == psw_pkg::PSW_OP_MUL |=> status_word[7:6] == 2'b00
        && status_word[2] == $past(prod > 16'h00ff))
        else $error("flags wrong after multiply");
    AST_DIV_RANGE: assert property (
        op_kind == psw_pkg::PSW_OP_DIV |=> status_word[2] == $past(op_b == 0))
        else $error("range flag wrong after divide");
    AST_PARITY: assert property (
        !$past(sys_rst) |-> status_word[0] == ^$past(acc_value))
        else $error("parity does not follow accumulator");
    AST_USER_KEEP: assert property (
        !sfr_wr && !bit_wr |=> $stable({status_word[5:3], status_word[1]}))
        else $error("software bits changed without a write");
    AST_REG_BANK: assert property (
        reg_access && !ext_access |=> mapped_addr_r ==
        {3'b000, $past(status_word[4:3]), $past(reg_num)})
        else $error("register access mapped to wrong bank");

    // main scenarios reached
    COV_ADD_CARRY: cover property (op_kind == psw_pkg::PSW_OP_ADD && sum9[8]);
    COV_DIV_ZERO: cover property (op_kind == psw_pkg::PSW_OP_DIV && op_b == 0);
    COV_BANK_3: cover property (reg_access && status_word[4:3] == 2'b11);
endmodule // psw_status_map_chk

bind psw_status_map psw_status_map_chk chk_u (.*);

/* File: test_status_word_and_memory_map.sv */
// self-checking bench for the status word and memory map block
`timescale 1ns/1ns
module test_status_word_and_memory_map;
    // clock, reset and requests to the model
    logic             core_clk = 1'b0;
    logic             sys_rst = 1'b1;
    psw_pkg::psw_op_t req_kind = psw_pkg::PSW_OP_NONE;
    logic [7:0]       req_a = 8'h00;
    logic [7:0]       req_b = 8'h00;
    // block inputs
    psw_pkg::psw_op_t op_kind;
    logic [7:0]       op_a, op_b, acc_value;
    logic [7:0]       sfr_addr = 8'hd0;
    logic [7:0]       sfr_wdata = 8'h00;
    logic [7:0]       data_addr = 8'h00;
    logic [7:0]       ext_wdata = 8'h00;
    logic [15:0]      ext_addr = 16'h0000;
    logic [15:0]      code_addr = 16'h0000;
    logic [2:0]       bit_sel = 3'h0;
    logic [2:0]       reg_num = 3'h5;
    logic             sfr_wr = 1'b0, bit_wr = 1'b0, bit_val = 1'b0;
    logic             reg_access = 1'b0, data_indirect = 1'b0;
    logic             data_bit = 1'b0, ext_access = 1'b0, ext_wr = 1'b0;
    logic             code_access = 1'b0;
    // block outputs and counters
    logic [7:0]       status_word, mapped_addr_r, ext_rdata;
    logic [2:0]       mapped_bit_r;
    psw_pkg::psw_space_t mapped_space_r;
    logic             code_valid_r, code_addr_ok_r;
    logic             small_valid, small_ok;
    int               num_errors = 0;
    int               cmp_count = 0;

    always #20 core_clk = ~core_clk;

    // far-side model and block
    psw_exec_model exec_u (.*);
    psw_status_map dut_u (.*);
    // small variant only answers the program range check here
    psw_status_map #(.BIG_VARIANT(1'b0)) dut_small_u (.*,
        .status_word    (),
        .mapped_addr_r  (),
        .mapped_bit_r   (),
        .mapped_space_r (),
        .code_valid_r   (small_valid),
        .code_addr_ok_r (small_ok),
        .ext_rdata      ()
    );

    // compare and count; case inequality so unknowns fail
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL %0t got %h want %h", $time, got, exp);
        end
    endtask

    // launch one operation, then check the three arithmetic flags
    task automatic arith(input psw_pkg::psw_op_t k,
                         input logic [7:0] a, b, exp);
        @(posedge core_clk);
        req_kind <= k;
        req_a <= a;
        req_b <= b;
        @(posedge core_clk);
        req_kind <= psw_pkg::PSW_OP_NONE;
        @(posedge core_clk);
        #1 chk(status_word & 8'hc4, exp);
    endtask

    // one-cycle write; a bit write packs value in v[7], bit in v[2:0]
    task automatic sfr_write(input logic bw, input logic [7:0] v);
        @(posedge core_clk);
        sfr_wdata <= v;
        bit_sel <= v[2:0];
        bit_val <= v[7];
        sfr_wr <= !bw;
        bit_wr <= bw;
        @(posedge core_clk);
        sfr_wr <= 1'b0;
        bit_wr <= 1'b0;
    endtask

    // mode is {bit, indirect}; eb is {bit position, space}
    task automatic decode(input logic [7:0] a, input logic [1:0] mode,
                          input logic [7:0] ea, input logic [4:0] eb);
        @(posedge core_clk);
        data_addr <= a;
        {data_bit, data_indirect} <= mode;
        @(posedge core_clk);
        #1 chk(mapped_addr_r, ea);
        chk({mapped_bit_r, mapped_space_r}, eb);
    endtask

    // program read check one cycle after the request
    // ok is the big variant's answer, ok_s the small variant's
    task automatic code_rd(input logic [15:0] a, input logic ok, ok_s);
        @(posedge core_clk);
        code_access <= 1'b1;
        code_addr <= a;
        @(posedge core_clk);
        code_access <= 1'b0;
        #1 chk({4'h0, code_valid_r, code_addr_ok_r, small_valid, small_ok},
               {5'h01, ok, 1'b1, ok_s});
    endtask

    task automatic end_sim;
        $display("compares %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        repeat (20) @(posedge core_clk);
        sys_rst <= 1'b0;
        #1 chk(status_word, 8'h00);
        arith(psw_pkg::PSW_OP_ADD, 8'h7f, 8'h01, 8'h44);
        arith(psw_pkg::PSW_OP_ADD, 8'hff, 8'h01, 8'hc0);
        arith(psw_pkg::PSW_OP_ADDC, 8'h0f, 8'h00, 8'h40);
        arith(psw_pkg::PSW_OP_SUBB, 8'h80, 8'h01, 8'h44);
        arith(psw_pkg::PSW_OP_OTH, 8'h00, 8'h00, 8'h04);
        arith(psw_pkg::PSW_OP_SUBB, 8'h00, 8'h01, 8'hc0);
        arith(psw_pkg::PSW_OP_MUL, 8'h10, 8'h10, 8'h04);
        arith(psw_pkg::PSW_OP_MUL, 8'h0f, 8'h11, 8'h00);
        arith(psw_pkg::PSW_OP_DIV, 8'h05, 8'h00, 8'h04);
        arith(psw_pkg::PSW_OP_DIV, 8'h05, 8'h01, 8'h00);
        arith(psw_pkg::PSW_OP_NONE, 8'h01, 8'h00, 8'h00);
        $display("arith test done");
        sfr_write(1'b0, 8'hff);
        #1 chk(status_word, 8'hff);
        arith(psw_pkg::PSW_OP_ADD, 8'h00, 8'h00, 8'h00);
        chk(status_word, 8'h3a);
        sfr_write(1'b1, 8'h05);
        #1 chk(status_word, 8'h1a);
        sfr_write(1'b1, 8'h80);
        #1 chk(status_word, 8'h1a);
        // a write to a neighbouring special address must not land
        sfr_addr <= 8'hd1;
        sfr_write(1'b0, 8'hff);
        sfr_addr <= 8'hd0;
        #1 chk(status_word, 8'h1a);
        $display("status test done");
        for (int b = 0; b < 4; b++) begin
            sfr_write(1'b0, {3'b000, b[1:0], 3'b000});
            reg_access <= 1'b1;
            @(posedge core_clk);
            reg_access <= 1'b0;
            #1 chk(mapped_addr_r, 8'(b * 8 + 5));
        end
        decode(8'h45, 2'b00, 8'h45, 5'h00);
        decode(8'h7f, 2'b01, 8'h7f, 5'h00);
        decode(8'h90, 2'b01, 8'h90, 5'h01);
        decode(8'h90, 2'b00, 8'h90, 5'h02);
        decode(8'h13, 2'b10, 8'h22, 5'h0c);
        decode(8'h00, 2'b10, 8'h20, 5'h00);
        decode(8'h7f, 2'b10, 8'h2f, 5'h1c);
        decode(8'hd5, 2'b10, 8'hd0, 5'h16);
        $display("decode test done");
        code_rd(16'h0000, 1'b1, 1'b1);
        code_rd(16'h1fff, 1'b1, 1'b1);
        code_rd(16'h2000, 1'b1, 1'b0);
        code_rd(16'h3dff, 1'b1, 1'b0);
        code_rd(16'h3e00, 1'b0, 1'b0);
        code_rd(16'hffff, 1'b0, 1'b0);
        @(posedge core_clk);
        ext_access <= 1'b1;
        ext_addr <= 16'h0005;
        ext_wr <= 1'b1;
        ext_wdata <= 8'ha5;
        @(posedge core_clk);
        ext_wr <= 1'b0;
        ext_addr <= 16'h0405;
        @(posedge core_clk);
        ext_access <= 1'b0;
        #1 chk(ext_rdata, 8'ha5);
        chk({6'h00, mapped_space_r}, 8'h03);
        $display("memory test done");
        // reset in mid-run clears a non-zero bank field and the decode
        @(posedge core_clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        #1 chk(status_word, 8'h00);
        chk(mapped_addr_r, 8'h00);
        chk({6'h00, mapped_space_r}, 8'h00);
        $display("reset test done");
        end_sim();
    end

    // watchdog: the tests need about 110 cycles
    initial begin
        #40000;
        num_errors++;
        end_sim();
    end
endmodule // test_status_word_and_memory_map
